/* rcm_pkg.sv */
package rcm_pkg;
  // clock rate and printed times
  localparam int CLK_MHZ    = 25;
  localparam int BIAS_US    = 10;
  localparam int POWER_UP_TIMER_A_MS  = 4;
  localparam int POWER_UP_TIMER_B_MS  = 16;
  localparam int POWER_UP_TIMER_C_MS  = 64;
  localparam int BIAS_CYC   = BIAS_US * CLK_MHZ;
  localparam int POWER_UP_TIMER_A_CYC = POWER_UP_TIMER_A_MS * 1000 * CLK_MHZ;
  localparam int POWER_UP_TIMER_B_CYC = POWER_UP_TIMER_B_MS * 1000 * CLK_MHZ;
  localparam int POWER_UP_TIMER_C_CYC = POWER_UP_TIMER_C_MS * 1000 * CLK_MHZ;
  localparam int PIN_FILT_CYC = 4;
  localparam logic [15:0] WDT_LIMIT = 16'hFFFF;
  // register offsets
  localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
  localparam logic [3:0] OFS_RST_CTRL = 4'h2;
  localparam logic [3:0] OFS_WDT_CNT  = 4'h4;
  // oscillator control fields
  localparam int OSC_CURRENT_OSCILLATOR_FIELD_HI = 14;
  localparam int OSC_CURRENT_OSCILLATOR_FIELD_LO = 12;
  localparam int OSC_REQ_FRC = 8;
  localparam int OSC_CF      = 3;
  localparam int OSC_SWREQ   = 0;
  localparam logic [2:0]  OSC_FRC    = 3'h1;
  localparam logic [1:0]  PRIM_OFF   = 2'h3;
  localparam logic [15:0] RST_POR_VAL = 16'h0001;
  localparam logic [23:0] VEC_RESET = 24'h000000;
  localparam logic [23:0] VEC_CFAIL = 24'h000004;
  localparam logic [23:0] PC_STEP   = 24'h000002;
  localparam logic [1:0] POWER_UP_TIMER_NONE = 2'h0;
  localparam logic [1:0] POWER_UP_TIMER_A    = 2'h1;
  localparam logic [1:0] POWER_UP_TIMER_B    = 2'h2;

  // reset control register layout
  typedef struct packed {
    logic       trap_lockup;
    logic       illegal_op;
    logic [5:0] rsv1;
    logic       ext_rst;
    logic       sw_rst;
    logic       sw_wdt_en;
    logic       wdt_to;
    logic       sleep;
    logic       idle;
    logic       rsv0;
    logic       por;
  } rcm_reset_control_reg_t;

  typedef struct packed {
    logic       wdt_en;
    logic [1:0] power_up_timer_sel;
    logic [1:0] mon_sel;
    logic [1:0] new_osc;
    logic [1:0] prim_mode;
  } rcm_cfg_t;

  typedef struct packed {
    logic running;
    logic ost_done;
    logic pll_lock;
    logic xtal_used;
    logic pll_used;
    logic fail;
  } rcm_clk_t;

  typedef struct packed {
    logic sw_reset;
    logic trap_lockup;
    logic illegal_op;
    logic int_wake;
    logic wdt_clear;
    logic sleep;
    logic idle;
  } rcm_cpu_t;

  typedef enum logic [4:0] {
    ST_BIAS = 5'b00001,
    ST_POWER_UP_TIMER = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_RUN  = 5'b01000,
    ST_PIN  = 5'b10000
  } rcm_state_t;
endpackage

/* rcm_top.sv */
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// R1 - monitor-select field pattern 1x disables switching and the clock monitor
// R2 - enabled monitor traps on oscillator failure and moves clock to fast RC
// R3 - failure loads fast RC code, sets clock-fail flag, clears switch request
// R4 - oscillator not started when power-up timer ends gives fast RC and clock-fail flag, no trap
// R5 - switching only between primary and fast RC groups; primary follows config
// R6 - switching off: config fields choose clock; current field only reflects it
// R7 - software should avoid clocks under 100 KHz while monitor enabled
// R8 - distinguish power-on, pin, pin-in-sleep, watchdog, software, lock-up, illegal
// R9 - watchdog wake-up leaves registers unchanged, resumes normal operation
// R10 - external reset pin is glitch filtered
// R11 - internal resets never drive the external reset pin
// R12 - supply rise pulse restarts timer, holds reset, selects fuse clock
// R13 - bias settle delay of 10 us precedes the power-up delay
// R14 - power-up delay none, 4, 16 or 64 ms follows bias delay
// R15 - reset releases on next first-phase clock edge, program counter to vector
// R16 - monitor on and clock not ready after timers moves to fast RC without a trap
// R17 - monitor and timer off: leave reset quickly, fast RC runs at once
// R18 - monitor off and no clock: stay frozen in reset until clock runs
// R19 - each reset sets own cause flag and loads program counter with zero
// R20 - untouched cause flags keep value; power-on clears all but its own
// R21 - watchdog wake resumes at PC + 2; interrupt wake loads its vector
// R22 - watchdog counts from its own RC ticks, independent of main clock
// R23 - watchdog timeout resets, or wakes in sleep; clear instruction restarts it
// R24 - clock-fail trap uses its own vector and leaves cause flags unchanged
module rcm_top
  import rcm_pkg::*;
#(
  parameter int P_POWER_UP_TIMER_A_CYC = POWER_UP_TIMER_A_CYC,
  parameter int P_POWER_UP_TIMER_B_CYC = POWER_UP_TIMER_B_CYC,
  parameter int P_POWER_UP_TIMER_C_CYC = POWER_UP_TIMER_C_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_por_pulse,
  input  wire logic        i_ext_rst_pin_n,
  input  wire rcm_cfg_t    i_cfg,
  input  wire rcm_clk_t    i_clk_st,
  input  wire rcm_cpu_t    i_cpu,
  input  wire logic [23:0] i_pc,
  input  wire logic [23:0] i_int_vector,
  input  wire logic        i_phase1,
  input  wire logic        i_wdt_tick,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  output logic             o_sys_rst_n,
  output logic [2:0]       o_clk_sel,
  output logic             o_cf_trap,
  output logic             o_wake,
  output logic             o_pc_load,
  output logic [23:0]      o_pc_value,
  output logic             o_ext_pin_o,
  output logic             o_ext_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [20:0] power_up_timer_len(input logic [1:0] sel);
    case (sel)
      POWER_UP_TIMER_NONE: power_up_timer_len = 21'h0;
      POWER_UP_TIMER_A:    power_up_timer_len = P_POWER_UP_TIMER_A_CYC[20:0];
      POWER_UP_TIMER_B:    power_up_timer_len = P_POWER_UP_TIMER_B_CYC[20:0];
      default:   power_up_timer_len = P_POWER_UP_TIMER_C_CYC[20:0];
    endcase
  endfunction

  function automatic logic [2:0] prim_code(input logic [1:0] nosc);
    prim_code = {1'b1, nosc};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state
  rcm_state_t  st_q, st_d;
  logic [20:0] cnt_q, cnt_d;
  rcm_reset_control_reg_t   rf_q, rf_d;
  logic [2:0]  current_oscillator_field_q;
  logic        cf_q, swreq_q, req_frc_q;
  logic [15:0] wdt_q;
  logic [2:0]  filt_q;
  logic        pin_low_q;
  logic        rst_q, trap_q, wake_q, pcl_q;
  logic [23:0] pcv_q;
  logic [15:0] rdata_q;
  logic        pin_o_q, pin_oe_q;

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  wire sw_en     = ~i_cfg.mon_sel[1];                      // R1
  wire mon_en    = (i_cfg.mon_sel == 2'h0);                // R1
  wire asleep    = i_cpu.sleep;
  wire dozing    = i_cpu.idle;
  wire wr_osc    = i_wr & (i_addr == OFS_OSC_CTRL);
  wire wr_rst    = i_wr & (i_addr == OFS_RST_CTRL);
  wire run       = (st_q == ST_RUN);
  wire on_frc    = (current_oscillator_field_q == OSC_FRC);
  wire clk_ready = i_clk_st.running & (i_clk_st.ost_done | ~i_clk_st.xtal_used)
                 & (i_clk_st.pll_lock | ~i_clk_st.pll_used);
  wire clk_ok    = on_frc | clk_ready;
  wire [2:0] fuse_osc = (i_cfg.prim_mode == PRIM_OFF) ? OSC_FRC
                      : prim_code(i_cfg.new_osc);
  wire wdt_on    = i_cfg.wdt_en | rf_q.sw_wdt_en;
  wire wdt_to    = run & wdt_on & i_wdt_tick & (wdt_q == WDT_LIMIT);   // R22

  // events, highest priority first, except that a clock failure in run outranks both wakes
  wire ev_por    = i_por_pulse;                                         // R12
  wire ev_pin    = ~ev_por & pin_low_q & (st_q != ST_PIN);              // R8
  wire ev_wrst   = ~ev_por & ~ev_pin & wdt_to & ~asleep;                // R23
  wire ev_wwake  = ~ev_por & ~ev_pin & wdt_to & asleep;                 // R23
  wire ev_lock   = ~ev_por & ~ev_pin & ~wdt_to & run & i_cpu.trap_lockup;
  wire ev_ill    = ~ev_por & ~ev_pin & ~wdt_to & run & ~i_cpu.trap_lockup
                 & i_cpu.illegal_op;
  wire ev_sw     = ~ev_por & ~ev_pin & ~wdt_to & run & ~i_cpu.trap_lockup
                 & ~i_cpu.illegal_op & i_cpu.sw_reset;
  wire ev_rst    = ev_wrst | ev_lock | ev_ill | ev_sw;
  // an interrupt wake yields to any reset in the same cycle
  wire ev_iwake  = ~ev_por & ~ev_pin & ~ev_rst & run & i_cpu.int_wake
                 & ~wdt_to;
  wire fail_run  = run & mon_en & i_clk_st.fail & ~on_frc;              // R2
  wire fail_wait = (st_q == ST_WAIT) & mon_en & ~clk_ok;                // R16 R4
  wire ev_fail   = ~ev_por & ~ev_pin & ~ev_rst & (fail_run | fail_wait);
  // monitor off and no ready clock: the wait state holds reset until the clock is ready
  wire release_now = (st_q == ST_WAIT) & clk_ok & i_phase1;             // R15 R18

  ////////////////////////////////////////////////////////////////////////////////
  // reset pin glitch filter: level must hold for the full count
  // a pulse shorter than the count restarts it and never reaches the core
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      filt_q    <= 3'h0;
      pin_low_q <= 1'b0;
    end else if (i_ext_rst_pin_n == ~pin_low_q) begin
      filt_q <= 3'h0;
    end else if (filt_q == 3'(PIN_FILT_CYC - 1)) begin
      filt_q    <= 3'h0;
      pin_low_q <= ~pin_low_q;                                          // R10
    end else begin
      filt_q <= filt_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power-up sequencer
  // bias delay, then the selected power-up delay, then wait for a ready clock
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q + 21'h1;
    case (st_q)
      ST_BIAS: begin
        if (cnt_q == 21'(BIAS_CYC - 1)) begin                           // R13
          cnt_d = 21'h0;
          st_d  = (i_cfg.power_up_timer_sel == POWER_UP_TIMER_NONE) ? ST_WAIT : ST_POWER_UP_TIMER;   // R17
        end
      end
      ST_POWER_UP_TIMER: begin
        if (cnt_q == power_up_timer_len(i_cfg.power_up_timer_sel) - 21'h1) begin            // R14
          cnt_d = 21'h0;
          st_d  = ST_WAIT;
        end
      end
      ST_WAIT: begin
        cnt_d = 21'h0;
        if (release_now) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        cnt_d = 21'h0;
      end
      ST_PIN: begin
        cnt_d = 21'h0;
        if (!pin_low_q) begin
          st_d = ST_BIAS;
        end
      end
      default: begin
        cnt_d = 21'h0;
        st_d  = ST_BIAS;
      end
    endcase
    if (ev_por) begin                                                   // R12
      st_d  = ST_BIAS;
      cnt_d = 21'h0;
    end else if (ev_pin) begin
      st_d  = ST_PIN;
      cnt_d = 21'h0;
    end else if (ev_rst) begin
      st_d  = ST_BIAS;
      cnt_d = 21'h0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st_q  <= ST_BIAS;
      cnt_q <= 21'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset cause flags; hardware events win over a software write
  // reserved bits always read back as zero
  always_comb begin
    rf_d = rf_q;
    if (wr_rst) begin
      rf_d = rcm_reset_control_reg_t'(i_wdata);
    end
    rf_d.rsv1 = 6'h0;
    rf_d.rsv0 = 1'b0;
    if (ev_por) begin
      rf_d = rcm_reset_control_reg_t'(RST_POR_VAL);                                  // R20
    end else if (ev_pin) begin
      rf_d.ext_rst = 1'b1;                                              // R19
      rf_d.wdt_to  = 1'b0;
      rf_d.sleep   = asleep;
      rf_d.idle    = dozing & ~asleep;
      if (!asleep && !dozing) begin
        rf_d.sw_rst = 1'b0;
      end
    end else if (ev_wrst) begin
      rf_d.ext_rst = 1'b0;                                              // R19
      rf_d.sw_rst  = 1'b0;
      rf_d.wdt_to  = 1'b1;
      rf_d.sleep   = 1'b0;
      rf_d.idle    = 1'b0;
    end else if (ev_wwake) begin
      rf_d.wdt_to = 1'b1;                                               // R21
      rf_d.sleep  = 1'b1;
    end else if (ev_lock) begin
      rf_d.trap_lockup = 1'b1;                                          // R8
    end else if (ev_ill) begin
      rf_d.illegal_op = 1'b1;                                           // R8
    end else if (ev_sw) begin
      rf_d.sw_rst  = 1'b1;                                              // R19
      rf_d.ext_rst = 1'b0;
      rf_d.wdt_to  = 1'b0;
      rf_d.sleep   = 1'b0;
      rf_d.idle    = 1'b0;
    end else if (ev_iwake) begin
      rf_d.sleep = rf_d.sleep | asleep;                                 // R21
      rf_d.idle  = rf_d.idle | (dozing & ~asleep);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rf_q <= rcm_reset_control_reg_t'(RST_POR_VAL);
    end else begin
      rf_q <= rf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: advances on low-power RC ticks only
  // clear, timeout, disable or leaving run restart the count at zero
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      wdt_q <= 16'h0;
    end else if (!run || i_cpu.wdt_clear || wdt_to || !wdt_on) begin
      wdt_q <= 16'h0;                                                   // R23
    end else if (i_wdt_tick) begin
      wdt_q <= wdt_q + 16'h1;                                           // R22
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // oscillator control: switching, clock-fail handling
  // a failure beats a software write in the same cycle, so the flag is never lost
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      current_oscillator_field_q    <= OSC_FRC;
      cf_q      <= 1'b0;
      swreq_q   <= 1'b0;
      req_frc_q <= 1'b0;
    end else if (ev_por) begin
      current_oscillator_field_q    <= fuse_osc;                                            // R12
      cf_q      <= 1'b0;
      swreq_q   <= 1'b0;
      req_frc_q <= 1'b0;
    end else if (ev_fail) begin
      current_oscillator_field_q  <= OSC_FRC;                                               // R3
      cf_q    <= 1'b1;                                                  // R3
      swreq_q <= 1'b0;                                                  // R3
    end else begin
      if (wr_osc) begin
        req_frc_q <= i_wdata[OSC_REQ_FRC];
        swreq_q   <= i_wdata[OSC_SWREQ];
        cf_q      <= i_wdata[OSC_CF];
      end
      if (!sw_en) begin
        current_oscillator_field_q  <= fuse_osc;                                            // R6
        swreq_q <= 1'b0;
      end else if (run && swreq_q) begin
        current_oscillator_field_q  <= req_frc_q ? OSC_FRC : prim_code(i_cfg.new_osc);      // R5
        swreq_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset output, program counter loads, trap and wake pulses
  // the trap pulses only in run; a failure in the wait state moves the clock to fast RC with no trap, then reset releases
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rst_q  <= 1'b0;
      trap_q <= 1'b0;
      wake_q <= 1'b0;
      pcl_q  <= 1'b0;
      pcv_q  <= VEC_RESET;
    end else begin
      trap_q <= ev_fail & run;                                          // R24
      wake_q <= (ev_wwake | ev_iwake) & ~(ev_fail & run);               // R9
      pcl_q  <= 1'b0;
      if (ev_por || ev_pin || ev_rst) begin
        rst_q <= 1'b0;                                                  // R12
      end else if (release_now) begin
        rst_q <= 1'b1;                                                  // R15
        pcl_q <= 1'b1;
        pcv_q <= VEC_RESET;                                             // R19
      end else if (ev_fail && run) begin
        pcl_q <= 1'b1;
        pcv_q <= VEC_CFAIL;                                             // R24
      end else if (ev_wwake) begin
        pcl_q <= 1'b1;
        pcv_q <= i_pc + PC_STEP;                                        // R21
      end else if (ev_iwake) begin
        pcl_q <= 1'b1;
        pcv_q <= i_int_vector;                                          // R21
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read port, data valid the cycle after the strobe only
  // unmapped offsets read as zero and take no write
  wire [15:0] osc_view = {1'b0, current_oscillator_field_q, 3'h0, req_frc_q, 4'h0, cf_q, 2'h0, swreq_q};
  wire [15:0] rd_mux   = (i_addr == OFS_OSC_CTRL) ? osc_view
                       : (i_addr == OFS_RST_CTRL) ? 16'(rf_q)
                       : (i_addr == OFS_WDT_CNT)  ? wdt_q : 16'h0;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rdata_q <= 16'h0;
    end else begin
      rdata_q <= i_rd ? rd_mux : 16'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin drive flops: the pin stays an input, internal resets never pull it low
  always_ff @(posedge i_sys_clk) begin
    pin_o_q  <= 1'b0;                                                   // R11
    pin_oe_q <= 1'b0;                                                   // R11
  end

  // outputs
  assign o_rdata      = rdata_q;
  assign o_sys_rst_n  = rst_q;
  assign o_clk_sel    = current_oscillator_field_q;
  assign o_cf_trap    = trap_q;
  assign o_wake       = wake_q;
  assign o_pc_load    = pcl_q;
  assign o_pc_value   = pcv_q;
  assign o_ext_pin_o  = pin_o_q;
  assign o_ext_pin_oe = pin_oe_q;

endmodule

/* rcm_osc_model.sv */
`timescale 1ns/1ps
// oscillator sources and core phase timing seen by the sequencer
module rcm_osc_model
  import rcm_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_tick_en,
  output rcm_clk_t        o_st,
  output logic            o_phase1,
  output logic            o_tick
);
  logic [1:0] ph_q = 2'h0;
  // mode 0 good, 1 slow start, 2 failed; never a clock below 100 KHz
  assign o_st = '{running: i_mode == 2'h0, ost_done: i_mode == 2'h0,
                  pll_lock: i_mode == 2'h0, xtal_used: 1'b1, pll_used: 1'b0,
                  fail: i_mode == 2'h2};
  // first phase pulse every fourth cycle, ticks every cycle while enabled
  assign o_phase1 = ph_q == 2'h3;
  assign o_tick   = i_tick_en;
  // phase counter
  always @(posedge i_clk) begin
    ph_q <= ph_q + 2'h1;
  end
endmodule

/* rcm_top_monitor.sv */
`timescale 1ns/1ps
// port checker for the sequencer
module rcm_top_monitor
  import rcm_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rstn,
  input wire logic        i_ext_rst_pin_n,
  input wire rcm_cfg_t    i_cfg,
  input wire rcm_clk_t    i_clk_st,
  input wire logic [23:0] i_pc,
  input wire logic [23:0] i_int_vector,
  input wire logic        i_phase1,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        o_sys_rst_n,
  input wire logic [2:0]  o_clk_sel,
  input wire logic        o_cf_trap,
  input wire logic        o_wake,
  input wire logic        o_pc_load,
  input wire logic [23:0] o_pc_value,
  input wire logic        o_ext_pin_o,
  input wire logic        o_ext_pin_oe
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic [8:0] low_q;
  // cycles spent in reset, saturating
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn || o_sys_rst_n) low_q <= 9'h000;
    else if (low_q != 9'h1FF) low_q <= low_q + 9'h001;
  end
  // pin held low while running, and the jump taken on release
  sequence s_pin_low;
    o_sys_rst_n ##0 !i_ext_rst_pin_n [*4];
  endsequence
  sequence s_release;
    o_pc_load && o_pc_value == VEC_RESET;
  endsequence
  pin_never_driven_a: assert property (!o_ext_pin_oe && !o_ext_pin_o)
    else $error("reset pin driven");
  read_slot_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside its slot");
  release_phase_a: assert property ($rose(o_sys_rst_n)
                                    |-> $past(i_phase1) ##0 s_release)
    else $error("reset release without phase or vector");
  bias_hold_a: assert property ($rose(o_sys_rst_n) |-> low_q >= BIAS_CYC)
    else $error("reset released before bias delay");
  trap_cause_a: assert property (o_cf_trap
                                 |-> $past(i_clk_st.fail) && $past(i_cfg.mon_sel) == 2'h0)
    else $error("trap without enabled monitor and failure");
  trap_vector_a: assert property (o_cf_trap |-> o_pc_load && o_pc_value == VEC_CFAIL
                                  && o_clk_sel == OSC_FRC)
    else $error("trap vector or clock wrong");
  wake_target_a: assert property (o_wake |-> o_pc_load && o_sys_rst_n
    && (o_pc_value == $past(i_pc) + PC_STEP || o_pc_value == $past(i_int_vector)))
    else $error("wake target wrong");
  frozen_reset_a: assert property (!o_sys_rst_n && i_cfg.mon_sel != 2'h0
                                   && !i_clk_st.running && o_clk_sel != OSC_FRC |=> !o_sys_rst_n)
    else $error("left reset without a clock");
  pin_reset_a: assert property (s_pin_low |-> ##[1:8] !o_sys_rst_n)
    else $error("pin reset not taken");
  clock_group_a: assert property (o_clk_sel == OSC_FRC || o_clk_sel == {1'b1, i_cfg.new_osc})
    else $error("clock outside the two groups");
endmodule
bind rcm_top rcm_top_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .i_ext_rst_pin_n(i_ext_rst_pin_n), .i_cfg(i_cfg), .i_clk_st(i_clk_st), .i_pc(i_pc),
  .i_int_vector(i_int_vector), .i_phase1(i_phase1), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_sys_rst_n(o_sys_rst_n), .o_clk_sel(o_clk_sel), .o_cf_trap(o_cf_trap), .o_wake(o_wake),
  .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_ext_pin_o(o_ext_pin_o),
  .o_ext_pin_oe(o_ext_pin_oe));

/* test_rcm_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
// bench for the reset and clock-fail sequencer
module test_rcm_top;
  import rcm_pkg::*;
  localparam int PA = 20;
  localparam int PB = 40;
  localparam int PC = 80;
  logic        clk = 1'b0, rstn = 1'b0, por = 1'b0, pin_n = 1'b1;
  logic        wr = 1'b0, rd = 1'b0, ten = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdat = 16'h0000, rdat, got, g0;
  logic [23:0] pc = 24'h000100, ivec = 24'h000040, pval;
  rcm_cfg_t    cfg = '0;
  rcm_cpu_t    cpu = '0;
  rcm_clk_t    cst;
  logic        ph, tick, srst_n, cf, wk, pld, po, poe;
  logic [2:0]  csel;
  logic [6:0]  pv [3] = '{7'h40, 7'h20, 7'h10};
  logic [15:0] ex [3] = '{16'h0040, 16'h8000, 16'h4000};
  int          n_mismatch = 0, n_tests = 0, n, k;
  ////////////////////////////////////////
  rcm_top #(.P_POWER_UP_TIMER_A_CYC(PA), .P_POWER_UP_TIMER_B_CYC(PB), .P_POWER_UP_TIMER_C_CYC(PC)) dut (.i_sys_clk(clk),
    .i_rstn(rstn), .i_por_pulse(por), .i_ext_rst_pin_n(pin_n), .i_cfg(cfg), .i_clk_st(cst),
    .i_cpu(cpu), .i_pc(pc), .i_int_vector(ivec), .i_phase1(ph), .i_wdt_tick(tick),
    .i_addr(addr), .i_wdata(wdat), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .o_sys_rst_n(srst_n),
    .o_clk_sel(csel), .o_cf_trap(cf), .o_wake(wk), .o_pc_load(pld), .o_pc_value(pval),
    .o_ext_pin_o(po), .o_ext_pin_oe(poe));
  rcm_osc_model u_osc (.i_clk(clk), .i_mode(mode), .i_tick_en(ten), .o_st(cst),
    .o_phase1(ph), .o_tick(tick));
  // free running clock
  initial forever #20 clk = ~clk;
  ////////////////////////////////////////
  task automatic complete_run;
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // register port cycles
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  // bounded wait: 0 leaves reset, 1 wake, 2 clock-fail trap
  task automatic wait_ev(input int sel, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (!(sel == 0 ? srst_n === 1'b1 : sel == 1 ? wk === 1'b1 : cf === 1'b1) && c < lim);
    if (c >= lim) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic por_pulse;
    @(posedge clk);
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
  endtask
  task automatic pulse(input rcm_cpu_t p);
    @(posedge clk);
    cpu <= rcm_cpu_t'(cpu | p);
    @(posedge clk);
    cpu <= rcm_cpu_t'(cpu & ~p);
  endtask
  task automatic pin_rst(input logic slp);
    @(posedge clk);
    pin_n <= 1'b0;
    cpu.sleep <= slp;
    repeat (8) @(posedge clk);
    pin_n <= 1'b1;
    cpu.sleep <= 1'b0;
    wait_ev(0, 2000, n);
  endtask
  // expected power-up delay for a selection code
  function automatic int power_up_timer_cyc(input logic [1:0] s);
    return s == POWER_UP_TIMER_NONE ? 0 : s == POWER_UP_TIMER_A ? PA : s == POWER_UP_TIMER_B ? PB : PC;
  endfunction
  ////////////////////////////////////////
  initial begin
    cfg.mon_sel = 2'h2;
    cfg.prim_mode = PRIM_OFF;
    cfg.new_osc = 2'h2;
    void'($urandom(98));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    wait_ev(0, 2000, n);
    `CHK("bias only", 1'b1, n >= BIAS_CYC - 2 && n <= BIAS_CYC + 8)
    `CHK("reset clock", OSC_FRC, csel)
    rd_reg(OFS_RST_CTRL, got);
    `CHK("reset_control_reg reset", RST_POR_VAL, got)
    wr_reg(4'hE, 16'($urandom));
    rd_reg(4'hE, got);
    `CHK("unmapped", 16'h0000, got)
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      cfg.power_up_timer_sel <= 2'(k);
      wr_reg(OFS_RST_CTRL, 16'h4040);
      por_pulse();
      wait_ev(0, 2000, n);
      `CHK("boot len", 1'b1, n >= BIAS_CYC + power_up_timer_cyc(2'(k)) - 2
                       && n <= BIAS_CYC + power_up_timer_cyc(2'(k)) + 8)
      rd_reg(OFS_RST_CTRL, got);
      `CHK("por flags", RST_POR_VAL, got)
    end
    @(posedge clk);
    cfg <= '{wdt_en: 1'b0, power_up_timer_sel: 2'h0, mon_sel: 2'h3, new_osc: 2'h2, prim_mode: 2'h0};
    mode <= 2'h1;
    por_pulse();
    repeat (400) @(posedge clk);
    `CHK("frozen", 1'b0, srst_n)
    mode <= 2'h0;
    wait_ev(0, 50, n);
    `CHK("fuse clock", 3'h6, csel)
    wr_reg(OFS_OSC_CTRL, 16'h0101);
    repeat (2) @(posedge clk);
    `CHK("no switch", 3'h6, csel)
    cfg.mon_sel <= 2'h0;
    mode <= 2'h1;
    por_pulse();
    wait_ev(0, 2000, n);
    `CHK("slow start", OSC_FRC, csel)
    rd_reg(OFS_OSC_CTRL, got);
    `CHK("slow cf", 1'b1, got[OSC_CF])
    mode <= 2'h0;
    wr_reg(OFS_OSC_CTRL, 16'h0001);
    repeat (2) @(posedge clk);
    `CHK("to primary", 3'h6, csel)
    wr_reg(OFS_OSC_CTRL, 16'h0101);
    repeat (2) @(posedge clk);
    `CHK("to fast rc", OSC_FRC, csel)
    wr_reg(OFS_OSC_CTRL, 16'h0001);
    rd_reg(OFS_RST_CTRL, g0);
    mode <= 2'h2;
    wait_ev(2, 20, n);
    `CHK("fail clock", OSC_FRC, csel)
    rd_reg(OFS_OSC_CTRL, got);
    `CHK("fail osc", {OSC_FRC, 2'h2}, {got[14:12], got[OSC_CF], got[OSC_SWREQ]})
    rd_reg(OFS_RST_CTRL, got);
    `CHK("trap flags", g0, got)
    mode <= 2'h0;
    wr_reg(OFS_OSC_CTRL, 16'h0001);
    for (k = 1; k < 4; k++) begin
      cfg.mon_sel <= 2'(k);
      mode <= 2'h2;
      n = 0;
      repeat (30) @(posedge clk) n += int'(cf === 1'b1);
      `CHK("monitor off", 0, n)
      mode <= 2'h0;
    end
    pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    pin_n <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("glitch", 1'b1, srst_n)
    pin_rst(1'b0);
    rd_reg(OFS_RST_CTRL, got);
    `CHK("pin flags", 16'h0081, got)
    wr_reg(OFS_RST_CTRL, 16'h0000);
    pin_rst(1'b1);
    rd_reg(OFS_RST_CTRL, got);
    `CHK("pin sleep", 16'h0088, got)
    for (k = 0; k < 3; k++) begin
      wr_reg(OFS_RST_CTRL, 16'h0000);
      pulse(pv[k]);
      wait_ev(0, 2000, n);
      rd_reg(OFS_RST_CTRL, got);
      `CHK("cause", ex[k], got)
    end
    wr_reg(OFS_RST_CTRL, 16'h0000);
    pc <= 24'($urandom);
    ivec <= 24'($urandom);
    cpu <= 7'h02;
    @(posedge clk);
    cpu <= 7'h0A;
    wait_ev(1, 20, n);
    `CHK("int vector", ivec, pval)
    cpu <= 7'h00;
    rd_reg(OFS_RST_CTRL, got);
    `CHK("int flags", 16'h0008, got)
    wr_reg(OFS_RST_CTRL, 16'h0020);
    ten <= 1'b1;
    repeat (20) @(posedge clk);
    rd_reg(OFS_WDT_CNT, got);
    `CHK("wdt runs", 1'b1, got > 16'h0008)
    pulse(7'h04);
    rd_reg(OFS_WDT_CNT, got);
    `CHK("wdt clear", 1'b1, got < 16'h0008)
    cpu <= 7'h02;
    wait_ev(1, 70000, n);
    `CHK("wdt wake", pc + PC_STEP, pval)
    `CHK("no reset", 1'b1, srst_n)
    cpu <= 7'h00;
    ten <= 1'b0;
    rd_reg(OFS_RST_CTRL, got);
    `CHK("wake flags", 16'h0038, got)
    complete_run();
  end
endmodule
